// ### tb/lha_lin_node.sv
// Partner model: other nodes on the wired-AND LIN line, plus the serial
// unit's byte-done answer. Assumes the bench sets node_low to pull low.
`timescale 1ns/10ps
`default_nettype none
module lha_lin_node #(
   parameter int DONE_DLY = 5
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Bus side
   input  wire logic lin_tx_pin,
   input  wire logic node_low,
   output var  logic bus_level,
   // Serial unit handshake
   input  wire logic serial_tx_req,
   output var  logic serial_tx_done
);
   int cnt;

   // Dominant low wins; the pull-up keeps the idle line high
   always_comb bus_level = lin_tx_pin & ~node_low;

   // Each byte takes a fixed time, so a second request never overlaps
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt            <= 0;
         serial_tx_done <= 1'b0;
      end else begin
         serial_tx_done <= (cnt == 1);
         if (serial_tx_req)
            cnt <= DONE_DLY;
         else if (cnt != 0)
            cnt <= cnt - 1;
      end
   end
endmodule : lha_lin_node
`default_nettype wire

// ### tb/lin_header_assist_tb.sv
// Bench for the LIN header assist: registers, master header, collision,
// slave break and sync measurement. Assumes lha_pkg and lha_core exist.
`timescale 1ns/10ps
`default_nettype none
module lin_header_assist_tb;
   import lha_pkg::*;
   localparam int          P     = 1;
   localparam int          C     = 2;
   localparam int          BRK   = (P + 1) * (C + 1);
   localparam int          BT    = 4;
   localparam logic [9:0]  FRAME = {1'b1, LHA_SYNC_BYTE, 1'b0};
   localparam logic [31:0] EN    = 32'h1 << LHA_C_ENABLE;
   localparam logic [31:0] MS    = 32'h1 << LHA_C_MASTER;
   localparam logic [31:0] ARM   = 32'h1 << LHA_C_ARM;
   localparam logic [31:0] TST   = 32'h1 << LHA_C_TIMER_COUNT_START;
   localparam logic [31:0] IE    = 32'h3 << LHA_C_BREAK_IRQ_ENABLE;
   localparam logic [31:0] TXEN  = 32'h1 << LHA_C_TXEN;
   localparam logic [31:0] BCI   = 32'h1 << LHA_C_BCIE;
   localparam logic [31:0] FWD   = 32'h1 << LHA_C_SYNCFWD;
   logic         clk      = 1'b0;
   logic         reset_n  = 1'b0;
   lha_apb_req_s req      = '0;
   lha_apb_rsp_s rsp;
   logic         tx, rx, rx_out, tx_req, tx_done, irq, err;
   logic         tx_bit   = 1'b1;
   logic         latch    = 1'b0;
   logic         rx_done  = 1'b0;
   logic         node_low = 1'b0;
   logic [7:0]   tx_byte;
   logic [31:0]  rd;
   logic [7:0]   sent[$];
   int           errors   = 0;
   int           n_tests  = 0;
   int           cycles   = 0;
   int           n;
   int           n_low    = 0;
   int           n0, t0;

   // 125 MHz system clock
   always #4 clk = ~clk;

   lha_core #(.TW(16)) DUT (.clk(clk), .reset_n(reset_n), .apb_req(req),
      .apb_rsp(rsp), .lin_rx_pin(rx), .lin_tx_pin(tx), .serial_rx_out(rx_out),
      .serial_tx_req(tx_req), .serial_tx_byte(tx_byte),
      .serial_tx_done(tx_done), .serial_rx_done(rx_done),
      .serial_tx_bit(tx_bit), .serial_latch(latch), .timer_irq(irq));

   lha_lin_node #(.DONE_DLY(5)) node (.clk(clk), .reset_n(reset_n),
      .lin_tx_pin(tx), .node_low(node_low), .bus_level(rx),
      .serial_tx_req(tx_req), .serial_tx_done(tx_done));

   // Log bytes sent, count receiver-side lows, cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (tx_req === 1'b1)
         sent.push_back(tx_byte);
      if (rx_out === 1'b0)
         n_low++;
      if (cycles == 20000) begin
         errors++;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   // One APB transfer; waits for pready with no assumed latency
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do
         @(posedge clk);
      while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask : apb

   task automatic drive(input logic low, input int cyc);
      node_low <= low;
      repeat (cyc) @(posedge clk);
   endtask : drive

   // Pull the bus low against a high transmit bit at the latch point
   task automatic collide();
      drive(1'b1, 3);
      latch <= 1'b1;
      @(posedge clk);
      latch <= 1'b0;
      drive(1'b0, 3);
      apb(1'b0, LHA_STAT_OFS, 32'h0);
   endtask : collide

   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      // Reset values and an unmapped word
      apb(1'b0, LHA_TPRE_OFS, 32'h0);
      chk("tpre reset", 32'h0000_00FF, rd);
      apb(1'b0, LHA_CTRL_OFS, 32'h0);
      chk("ctrl reset", 32'h0, rd);
      apb(1'b1, 8'h18, 32'hFFFF_FFFF);
      chk("unmapped error", 32'h1, err);
      // Master header
      apb(1'b1, LHA_TPRE_OFS, 32'(P));
      apb(1'b1, LHA_TCNT_OFS, 32'(C));
      apb(1'b1, LHA_DATA_OFS, 32'h0000_003C);
      apb(1'b1, LHA_CTRL_OFS, EN | MS | IE | TXEN | BCI);
      apb(1'b1, LHA_CTRL_OFS, EN | MS | IE | TXEN | BCI | TST);
      n = 0;
      while (tx !== 1'b0 && n < 8) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (tx === 1'b0) begin
         @(posedge clk);
         n++;
      end
      chk("break length", 32'(BRK), 32'(n));
      repeat (30) @(posedge clk);
      chk("bytes sent", 32'h2, 32'(sent.size()));
      chk("sync byte", 32'(LHA_SYNC_BYTE), 32'(sent[0]));
      chk("id byte", 32'h3C, 32'(sent[1]));
      apb(1'b0, LHA_STAT_OFS, 32'h0);
      chk("break done flag", 32'h1, rd[LHA_S_BREAK]);
      chk("break irq", 32'h1, irq);
      apb(1'b1, LHA_STAT_OFS, 32'h0000_0017);
      repeat (2) @(posedge clk);
      chk("irq after clear", 32'h0, irq);
      // Collision with transmit on, then off
      collide();
      chk("collision", 32'h1, rd[LHA_S_COLL]);
      chk("collision irq", 32'h1, irq);
      apb(1'b1, LHA_STAT_OFS, 32'h0000_0017);
      apb(1'b1, LHA_CTRL_OFS, EN | MS);
      collide();
      chk("collision tx off", 32'h0, rd[LHA_S_COLL]);
      // Slave: halt first, then an unarmed low must pass unnoticed
      apb(1'b1, LHA_CTRL_OFS, 32'h0);
      apb(1'b1, LHA_STAT_OFS, 32'h0000_0017);
      apb(1'b1, LHA_CTRL_OFS, EN | IE);
      drive(1'b1, BRK + 6);
      drive(1'b0, 4);
      apb(1'b0, LHA_STAT_OFS, 32'h0);
      chk("break unarmed", 32'h0, rd[LHA_S_BREAK]);
      apb(1'b1, LHA_CTRL_OFS, EN | IE | ARM);
      n = 0;
      do begin
         apb(1'b0, LHA_STAT_OFS, 32'h0);
         n++;
      end while (rd[LHA_S_RXRDY] !== 1'b1 && n < 20);
      chk("rx ready", 32'h1, rd[LHA_S_RXRDY]);
      drive(1'b1, BRK + 2);
      drive(1'b0, 3);
      apb(1'b0, LHA_STAT_OFS, 32'h0);
      chk("break detect", 32'h1, rd[LHA_S_BREAK]);
      chk("slave break irq", 32'h1, irq);
      // Header timeout runs from the break interrupt
      t0 = cycles;
      apb(1'b1, LHA_STAT_OFS, 32'h0000_0017);
      n0 = n_low;
      for (int i = 0; i < 10; i++)
         drive(~FRAME[i], BT);
      drive(1'b0, 4);
      chk("sync withheld", 32'h0, 32'(n_low - n0));
      apb(1'b0, LHA_STAT_OFS, 32'h0);
      chk("sync flag", 32'h1, rd[LHA_S_SYNC]);
      chk("sync irq", 32'h1, irq);
      apb(1'b0, LHA_CAPT_OFS, 32'h0);
      chk("sync capture", 32'(8 * BT), rd);
      apb(1'b1, LHA_TCNT_OFS, rd >> 3);
      rx_done <= 1'b1;
      @(posedge clk);
      rx_done <= 1'b0;
      apb(1'b0, LHA_STAT_OFS, 32'h0);
      chk("id received", 32'h1, rd[LHA_S_IDDONE]);
      chk("header in time", 32'h1, 32'(cycles - t0 < 200));
      // Long low during the response phase
      apb(1'b1, LHA_STAT_OFS, 32'h0000_0017);
      drive(1'b1, 40);
      drive(1'b0, 3);
      apb(1'b0, LHA_STAT_OFS, 32'h0);
      chk("long low break", 32'h1, rd[LHA_S_BREAK]);
      // Slave again, sync field forwarded; break period is now 10 cycles
      apb(1'b1, LHA_CTRL_OFS, 32'h0);
      apb(1'b1, LHA_STAT_OFS, 32'h0000_0017);
      apb(1'b1, LHA_CTRL_OFS, EN | ARM | FWD);
      apb(1'b0, LHA_STAT_OFS, 32'h0);
      chk("rx ready again", 32'h1, rd[LHA_S_RXRDY]);
      drive(1'b1, 2 * BRK);
      drive(1'b0, 3);
      n0 = n_low;
      for (int i = 0; i < 10; i++)
         drive(~FRAME[i], BT);
      drive(1'b0, 4);
      chk("sync forwarded", 32'(5 * BT), 32'(n_low - n0));
      apb(1'b0, LHA_STAT_OFS, 32'h0);
      chk("sync flag forwarded", 32'h1, rd[LHA_S_SYNC]);
      // End processing once the header is in
      apb(1'b1, LHA_CTRL_OFS, 32'h0);
      apb(1'b0, LHA_STAT_OFS, 32'h0);
      chk("halted rx ready", 32'h0, rd[LHA_S_RXRDY]);
      wrap_up();
   end
endmodule : lin_header_assist_tb
`default_nettype wire

// ### verilog/lha_core.sv
// LIN header assist: break generation/detection, sync measurement,
// collision check, one shared timer interrupt, APB register slave.
// Assumes the serial unit sits beside it and exchanges bytes by strobes.
//
// Operation
// RULE1: master start drives tx low for timer period
// RULE2: timer underflow releases tx, sets break flag
// RULE3: break flag raises interrupt when enabled
// RULE4: after break, request sync byte 55h
// RULE5: then identifier byte, then response phase
// RULE6: slave detection armed only by arm bit
// RULE7: software waits rx ready before break arrives
// RULE8: low rx for timer period means break
// RULE9: timer measures start plus bits 0-6
// RULE10: control bit forwards or withholds sync field
// RULE11: sync done sets flag, interrupt when enabled
// RULE12: software reprograms rate after sync measurement
// RULE13: slave responds only after identifier received
// RULE14: collision check needs transmit enable bit
// RULE15: rx differing from tx sets collision flag
// RULE16: long low during traffic sets break flag
// RULE17: all events share one interrupt output
// RULE18: software disables before changing mode
// RULE19: software ends after checksum or header
// RULE20: software times out with another timer
// RULE21: no wake-up detection in this block
// RULE22: flags sticky until software clears them
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module lha_core
   import lha_pkg::*;
#(
   parameter int TW = 16
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   // APB slave
   input  wire lha_pkg::lha_apb_req_s apb_req,
   output var  lha_pkg::lha_apb_rsp_s apb_rsp,
   // LIN pins
   input  wire logic                  lin_rx_pin,
   output var  logic                  lin_tx_pin,
   // Serial unit side
   output var  logic                  serial_rx_out,
   output var  logic                  serial_tx_req,
   output var  logic [7:0]            serial_tx_byte,
   input  wire logic                  serial_tx_done,
   input  wire logic                  serial_rx_done,
   input  wire logic                  serial_tx_bit,
   input  wire logic                  serial_latch,
   // Timer interrupt
   output var  logic                  timer_irq
);
   import lha_pkg::*;

   typedef struct packed {
      lha_state_e    st;
      logic [9:0]    ctrl;
      logic [2:0]    flags;    // Break, sync, collision
      logic          id_done;
      logic [7:0]    tpre;
      logic [7:0]    tcnt;
      logic [TW-1:0] cnt;      // Break timer down-counter
      logic [TW-1:0] meas;     // Sync measurement up-counter
      logic [TW-1:0] capt;
      logic [3:0]    edges;
      logic          rx_q;
      logic [7:0]    idbyte;
      logic          rx_rdy;
      lha_apb_rsp_s  rsp;
      logic          tx;
      logic          srx;
      logic          treq;
      logic [7:0]    tbyte;
      logic          irq;
   } lha_state_s;

   lha_state_s s_reg, s_next;

   // Period loaded into the timer: prescaler times counter, both plus one
   function automatic logic [TW-1:0] load_val(input logic [7:0] p,
                                              input logic [7:0] c);
      logic [16:0] prod;
      prod = 17'({9'd0, p} + 17'd1) * 17'({9'd0, c} + 17'd1);
      return TW'(prod - 17'd1);
   endfunction : load_val

   logic apb_acc, apb_wr, fall, tx_line;
   assign apb_acc = apb_req.psel & apb_req.penable;
   assign apb_wr  = apb_acc & apb_req.pwrite;
   assign fall    = s_reg.rx_q & ~lin_rx_pin;
   assign tx_line = (s_reg.st == LHA_BREAK && s_reg.ctrl[LHA_C_MASTER])
                    ? s_reg.tx : serial_tx_bit;

   // Next-state logic for bus, sequencer and flags
   always_comb begin
      logic [2:0] set;
      logic       run;
      logic       id_set;
      s_next = s_reg;
      set    = 3'b000;
      id_set = 1'b0;
      run    = s_reg.ctrl[LHA_C_ENABLE];
      s_next.rx_q = lin_rx_pin;
      s_next.treq = 1'b0;
      s_next.rsp.pready  = apb_req.psel & ~apb_req.penable;
      s_next.rsp.pslverr = 1'b0;
      s_next.rsp.prdata  = LHA_ERR_DATA;
      s_next.ctrl[LHA_C_TIMER_COUNT_START] = 1'b0;  // Self-clearing start strobe
      if (!run) begin
         s_next.st     = LHA_IDLE;
         s_next.tx     = 1'b1;
         s_next.rx_rdy = 1'b0;
      end else begin
         case (s_reg.st)
            LHA_IDLE: begin
               if (s_reg.ctrl[LHA_C_MASTER] && s_reg.ctrl[LHA_C_TIMER_COUNT_START]) begin
                  s_next.tx  = 1'b0;                              // [RULE1]
                  s_next.cnt = load_val(s_reg.tpre, s_reg.tcnt);
                  s_next.st  = LHA_BREAK;
               end else if (!s_reg.ctrl[LHA_C_MASTER]
                            && s_reg.ctrl[LHA_C_ARM]) begin       // [RULE6]
                  s_next.rx_rdy = lin_rx_pin;
                  s_next.cnt    = load_val(s_reg.tpre, s_reg.tcnt);
                  if (lin_rx_pin) s_next.st = LHA_WAITH;
               end
            end
            LHA_WAITH: begin
               // Low run as long as the timer period is a break
               if (lin_rx_pin) begin
                  s_next.cnt = load_val(s_reg.tpre, s_reg.tcnt);
               end else if (s_reg.cnt == '0) begin
                  set[0]       = 1'b1;                            // [RULE8]
                  s_next.meas  = '0;
                  s_next.edges = '0;
                  s_next.st    = LHA_SYNC;
               end else begin
                  s_next.cnt = s_reg.cnt - 1'b1;
               end
            end
            LHA_BREAK: begin
               if (s_reg.ctrl[LHA_C_MASTER]) begin
                  if (s_reg.cnt == '0) begin
                     s_next.tx    = ~s_reg.tx;                    // [RULE2]
                     set[0]       = 1'b1;
                     s_next.treq  = 1'b1;
                     s_next.tbyte = LHA_SYNC_BYTE;                // [RULE4]
                     s_next.st    = LHA_SYNC;
                  end else begin
                     s_next.cnt = s_reg.cnt - 1'b1;
                  end
               end
            end
            LHA_SYNC: begin
               if (s_reg.ctrl[LHA_C_MASTER]) begin
                  if (serial_tx_done) begin
                     s_next.treq  = 1'b1;                         // [RULE5]
                     s_next.tbyte = s_reg.idbyte;
                     s_next.st    = LHA_IDENT;
                  end
               end else begin
                  // Count from start-bit fall to fall after bit 6
                  if (s_reg.edges != '0) s_next.meas = s_reg.meas + 1'b1;
                  if (fall) begin
                     s_next.edges = s_reg.edges + 1'b1;
                     if (s_reg.edges == LHA_SYNC_EDGES) begin
                        // Count includes the closing cycle of the span
                        s_next.capt = s_reg.meas + 1'b1;          // [RULE9]
                        set[1]      = 1'b1;                       // [RULE11]
                     end
                  end
                  // Keep withholding through bit 7; a lone low would look
                  // like a start bit to the serial receiver
                  if (s_reg.edges > LHA_SYNC_EDGES && lin_rx_pin)
                     s_next.st = LHA_IDENT;
               end
            end
            LHA_IDENT: begin
               if (s_reg.ctrl[LHA_C_MASTER] ? serial_tx_done
                                             : serial_rx_done) begin
                  id_set         = 1'b1;                          // [RULE13]
                  s_next.cnt     = load_val(s_reg.tpre, s_reg.tcnt);
                  s_next.st      = LHA_RESP;                      // [RULE5]
               end
            end
            LHA_RESP: begin
               // Low as long as the timer period during traffic, same as a break
               if (lin_rx_pin) begin
                  s_next.cnt = load_val(s_reg.tpre, s_reg.tcnt);
               end else if (s_reg.cnt == '0) begin
                  set[0] = 1'b1;                                  // [RULE16]
               end else begin
                  s_next.cnt = s_reg.cnt - 1'b1;
               end
            end
            default: s_next.st = LHA_IDLE;
         endcase
      end
      // Collision compare at latch point; break phase needs enable too
      if (run && s_reg.ctrl[LHA_C_TXEN] && serial_latch    // [RULE14]
          && (s_reg.st != LHA_BREAK || s_reg.ctrl[LHA_C_BCE])
          && lin_rx_pin != tx_line)
         set[2] = 1'b1;                                           // [RULE15]
      // In slave mode the sync field is withheld from the serial receiver unless forwarded
      s_next.srx = (s_reg.st == LHA_SYNC && !s_reg.ctrl[LHA_C_MASTER]
                    && !s_reg.ctrl[LHA_C_SYNCFWD])  // [RULE10]
                   ? 1'b1 : lin_rx_pin;
      // APB access; write-one-to-clear, but a same-cycle set wins
      if (apb_wr) begin
         case (apb_req.paddr)
            LHA_CTRL_OFS: s_next.ctrl = apb_req.pwdata[9:0];
            LHA_STAT_OFS: begin
               s_next.flags   = s_reg.flags & ~apb_req.pwdata[2:0];
               if (apb_req.pwdata[LHA_S_IDDONE]) s_next.id_done = 1'b0;
            end
            LHA_TPRE_OFS: s_next.tpre = apb_req.pwdata[7:0];
            LHA_TCNT_OFS: s_next.tcnt = apb_req.pwdata[7:0];
            LHA_DATA_OFS: s_next.idbyte = apb_req.pwdata[7:0];
            LHA_CAPT_OFS: ;
            default: s_next.rsp.pslverr = apb_req.psel & ~apb_req.penable;
         endcase
      end
      s_next.flags = s_next.flags | set;                          // [RULE22]
      s_next.id_done = s_next.id_done | id_set;   // Set wins over a clear
      if (apb_req.psel && !apb_req.penable) begin
         case (apb_req.paddr)
            LHA_CTRL_OFS: s_next.rsp.prdata = 32'(s_reg.ctrl);
            LHA_STAT_OFS: s_next.rsp.prdata = 32'({s_reg.id_done,
                             s_reg.rx_rdy, s_reg.flags});
            LHA_TPRE_OFS: s_next.rsp.prdata = 32'(s_reg.tpre);
            LHA_TCNT_OFS: s_next.rsp.prdata = 32'(s_reg.tcnt);
            LHA_CAPT_OFS: s_next.rsp.prdata = 32'(s_reg.capt);
            LHA_DATA_OFS: s_next.rsp.prdata = 32'(s_reg.idbyte);
            default:      s_next.rsp.pslverr = 1'b1;
         endcase
      end
      // Shared interrupt from all event flags
      s_next.irq = (s_next.flags[0] & s_next.ctrl[LHA_C_BREAK_IRQ_ENABLE])        // [RULE3]
                 | (s_next.flags[1] & s_next.ctrl[LHA_C_SYNC_IRQ_ENABLE])
                 | (s_next.flags[2] & s_next.ctrl[LHA_C_BCIE]);       // [RULE17]
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_reg       <= '0;
         s_reg.st    <= LHA_IDLE;
         s_reg.ctrl  <= LHA_CTRL_RST;
         s_reg.tpre  <= LHA_TPRE_RST;
         s_reg.tcnt  <= LHA_TCNT_RST;
         s_reg.rx_q  <= 1'b1;
         s_reg.tx    <= 1'b1;
         s_reg.srx   <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from flops; no wake-up logic lives here [RULE21]
   assign apb_rsp        = s_reg.rsp;
   assign lin_tx_pin     = s_reg.tx;
   assign serial_rx_out  = s_reg.srx;
   assign serial_tx_req  = s_reg.treq;
   assign serial_tx_byte = s_reg.tbyte;
   assign timer_irq      = s_reg.irq;

   // Assertions
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_brk_low;
      s_reg.st == LHA_BREAK && s_reg.ctrl[LHA_C_MASTER] |-> !lin_tx_pin;
   endproperty
   a_brk_low: assert property (p_brk_low)  // [RULE1]
      else $error("tx not low during break");

   property p_brk_end;
      s_reg.st == LHA_BREAK && s_reg.ctrl[LHA_C_MASTER] && s_reg.cnt == '0
      && s_reg.ctrl[LHA_C_ENABLE]
      |=> lin_tx_pin && s_reg.flags[0] && serial_tx_req
          && serial_tx_byte == LHA_SYNC_BYTE;
   endproperty
   a_brk_end: assert property (p_brk_end)  // [RULE2]
      else $error("break end did not flip tx and request sync");

   property p_irq;
      s_reg.flags[0] && s_reg.ctrl[LHA_C_BREAK_IRQ_ENABLE] |-> timer_irq;
   endproperty
   a_irq: assert property (p_irq)  // [RULE3]
      else $error("break irq missing");

   property p_sync_irq;
      s_reg.flags[1] && s_reg.ctrl[LHA_C_SYNC_IRQ_ENABLE] |-> timer_irq;
   endproperty
   a_sync_irq: assert property (p_sync_irq)  // [RULE11]
      else $error("sync irq missing");

   property p_noarm;
      s_reg.st == LHA_IDLE && !s_reg.ctrl[LHA_C_ARM]
      && !s_reg.ctrl[LHA_C_TIMER_COUNT_START] |=> s_reg.st == LHA_IDLE;
   endproperty
   a_noarm: assert property (p_noarm)  // [RULE6]
      else $error("left idle without arm");

   property p_withhold;
      s_reg.st == LHA_SYNC && !s_reg.ctrl[LHA_C_MASTER]
      && !s_reg.ctrl[LHA_C_SYNCFWD] |=> serial_rx_out;
   endproperty
   a_withhold: assert property (p_withhold)  // [RULE10]
      else $error("sync field leaked to receiver");

   property p_sticky;
      s_reg.flags[2] && !(apb_wr && apb_req.paddr == LHA_STAT_OFS)
      |=> s_reg.flags[2];
   endproperty
   a_sticky: assert property (p_sticky)  // [RULE22]
      else $error("collision flag dropped");

   property p_resp;
      $rose(s_reg.st == LHA_RESP) |-> s_reg.id_done;
   endproperty
   a_resp: assert property (p_resp)  // [RULE13]
      else $error("response before identifier");

   c_break: cover property (s_reg.st == LHA_BREAK ##1 s_reg.st == LHA_SYNC);
   c_sync:  cover property (s_reg.st == LHA_SYNC ##1 s_reg.st == LHA_IDENT);
   c_coll:  cover property (!s_reg.flags[2] ##1 s_reg.flags[2]);
endmodule : lha_core
`default_nettype wire

// ### verilog/lha_pkg.sv
// Package for the LIN header assist: register map, field layout, states.
// Assumes a 32-bit APB slave with word-aligned registers.
package lha_pkg;
   // Register byte offsets
   localparam logic [7:0] LHA_CTRL_OFS = 8'h00;
   localparam logic [7:0] LHA_STAT_OFS = 8'h04;
   localparam logic [7:0] LHA_TPRE_OFS = 8'h08;
   localparam logic [7:0] LHA_TCNT_OFS = 8'h0C;
   localparam logic [7:0] LHA_CAPT_OFS = 8'h10;
   localparam logic [7:0] LHA_DATA_OFS = 8'h14;
   // Control register bit positions
   localparam int LHA_C_ENABLE  = 0;
   localparam int LHA_C_MASTER  = 1;
   localparam int LHA_C_ARM     = 2;
   localparam int LHA_C_TIMER_COUNT_START  = 3;
   localparam int LHA_C_BREAK_IRQ_ENABLE    = 4;
   localparam int LHA_C_SYNC_IRQ_ENABLE    = 5;
   localparam int LHA_C_BCIE    = 6;
   localparam int LHA_C_SYNCFWD = 7;
   localparam int LHA_C_BCE     = 8;
   localparam int LHA_C_TXEN    = 9;
   // Status register bit positions
   localparam int LHA_S_BREAK   = 0;
   localparam int LHA_S_SYNC    = 1;
   localparam int LHA_S_COLL    = 2;
   localparam int LHA_S_RXRDY   = 3;
   localparam int LHA_S_IDDONE  = 4;
   // Reset values and constants
   localparam logic [9:0]  LHA_CTRL_RST = 10'h000;
   localparam logic [7:0]  LHA_TPRE_RST = 8'hFF;
   localparam logic [7:0]  LHA_TCNT_RST = 8'hFF;
   localparam logic [7:0]  LHA_SYNC_BYTE = 8'h55;
   localparam logic [3:0]  LHA_SYNC_EDGES = 4'h4; // Falls: start..bit 6
   localparam logic [31:0] LHA_ERR_DATA = 32'h0000_0000;

   typedef enum logic [2:0] {
      LHA_IDLE  = 3'b000,
      LHA_BREAK = 3'b001,
      LHA_SYNC  = 3'b011,
      LHA_IDENT = 3'b010,
      LHA_RESP  = 3'b110,
      LHA_WAITH = 3'b111
   } lha_state_e;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } lha_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } lha_apb_rsp_s;
endpackage : lha_pkg
